// ===== pcd_pkg.sv
// Summary of operation
// - consumer port bitmap at tail offset 10
// - bit0 upstream port, others hub downstream ports
// - charging release BCD at offset 12
// - power delivery release BCD at offset 14
// - type-c release BCD at offset 16
// - one battery descriptor per declared battery
// - length, type, capability code open descriptors
// - battery string indices at offsets 3-5
// - unique battery identifier at offset 6
// - reserved bytes always read zero
// - full charge level, mWh, offset 8
// - minimum boot charge, mWh, offset 12
// - design and recent capacity at 16, 20
// - consumer descriptors per flagged port, ascending
// - peripheral one sink port, hub sixteen
// - sink method bits 0-2, rest zero
// - voltage floor/ceiling at 6/8, 50mV
// - steady power limit at 12, 10mW
// - burst power limit at 16, 10mW
// - burst duration at 20, 0xFFFF unknown
package pcd_pkg;
  // apb register byte offsets
  localparam logic [7:0] ATTR_OFS = 8'h00;
  localparam logic [7:0] SINK_MAP_OFS = 8'h04;
  localparam logic [7:0] CFG_OFS = 8'h08;
  localparam logic [7:0] REL_BC_OFS = 8'h0C;
  localparam logic [7:0] REL_PD_OFS = 8'h10;
  localparam logic [7:0] REL_TC_OFS = 8'h14;
  localparam logic [7:0] BAT_SEL_OFS = 8'h18;
  localparam logic [7:0] BAT_STR_OFS = 8'h1C;
  localparam logic [7:0] BAT_FULL_OFS = 8'h20;
  localparam logic [7:0] BAT_BOOT_OFS = 8'h24;
  localparam logic [7:0] BAT_DESIGN_OFS = 8'h28;
  localparam logic [7:0] BAT_RECENT_OFS = 8'h2C;
  localparam logic [7:0] PORT_SEL_OFS = 8'h30;
  localparam logic [7:0] PORT_METHOD_OFS = 8'h34;
  localparam logic [7:0] PORT_VOLT_OFS = 8'h38;
  localparam logic [7:0] PORT_STEADY_OFS = 8'h3C;
  localparam logic [7:0] PORT_BURST_OFS = 8'h40;
  localparam logic [7:0] PORT_DUR_OFS = 8'h44;
  localparam logic [7:0] STATUS_OFS = 8'h48;
  // capability_attribute_bits field positions
  localparam int ATTR_BC_BIT = 1;
  localparam int ATTR_PD_BIT = 2;
  localparam int ATTR_TC_BIT = 6;
  localparam int ORIGIN_BAT_BIT = 9;
  localparam int ORIGIN_NBAT_LO = 11;
  localparam logic [15:0] ATTR_WRITABLE = 16'h7F7F;
  localparam logic [2:0] METHOD_MASK = 3'h7;
  // reset values
  localparam logic [15:0] REL_BC_RESET = 16'h0120;
  localparam logic [31:0] DUR_UNKNOWN = 32'h0000FFFF;
  // descriptor framing
  localparam logic [7:0] DESC_LEN = 8'h18;
  localparam logic [7:0] DEVCAP_TYPE = 8'h10;
  localparam int NUM_BATS = 7;
  localparam int NUM_PORTS = 16;
  // fetch kinds
  localparam logic [1:0] KIND_TAIL = 2'h0;
  localparam logic [1:0] KIND_BAT = 2'h1;
  localparam logic [1:0] KIND_SINK = 2'h2;
  localparam int FETCH_LATENCY = 3;

  typedef struct packed {
    logic [1:0] kind;
    logic [3:0] index;
    logic [4:0] offset;
  } pcd_fetch_req_t;

  typedef struct packed {
    logic [7:0] name_idx;
    logic [7:0] serial_idx;
    logic [7:0] maker_idx;
    logic [7:0] ident;
  } pcd_bat_str_t;
endpackage

// ===== pcd_nth_port.sv
`timescale 1ns/1ps
// finds the port number of the n-th set bit, counting from bit 0 upward
module pcd_nth_port
  import pcd_pkg::*;
(
  input wire logic [15:0] port_map,
  input wire logic [3:0] nth,
  output logic [3:0] port_num,
  output logic found
);
  logic [4:0] seen;

  // walk ascending so descriptor order follows port order
  always_comb begin
    seen = 5'h00;
    port_num = 4'h0;
    found = 1'b0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (port_map[i]) begin
        if (!found && seen == {1'b0, nth}) begin
          port_num = 4'(i);
          found = 1'b1;
        end
        seen = seen + 5'h01;
      end
    end
  end
endmodule

// ===== pcd_desc_gen.sv
`timescale 1ns/1ps
module pcd_desc_gen
  import pcd_pkg::*;
#(
  parameter logic [7:0] BAT_CAP_CODE = 8'h01, // capability codes: plain defaults
  parameter logic [7:0] SINK_CAP_CODE = 8'h02
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire pcd_fetch_req_t fetch_req,
  output logic fetch_ready,
  output logic fetch_done,
  output logic [7:0] fetch_byte,
  output logic fetch_miss
);
  typedef enum {ST_IDLE, ST_LOOKUP, ST_REPLY} pcd_state_t;

  logic [15:0] attr_reg;
  logic [15:0] sink_map_reg;
  logic cfg_hub_reg;
  logic [15:0] rel_bc_reg, rel_pd_reg, rel_tc_reg;
  logic [2:0] bat_sel_reg;
  logic [3:0] port_sel_reg;
  pcd_bat_str_t bat_str [NUM_BATS];
  logic [31:0] bat_full [NUM_BATS];
  logic [31:0] bat_boot [NUM_BATS];
  logic [31:0] bat_design [NUM_BATS];
  logic [31:0] bat_recent [NUM_BATS];
  logic [2:0] port_method [NUM_PORTS];
  logic [31:0] port_volt [NUM_PORTS];
  logic [31:0] port_steady [NUM_PORTS];
  logic [31:0] port_burst [NUM_PORTS];
  logic [31:0] port_dur [NUM_PORTS];
  pcd_state_t state_reg;
  pcd_fetch_req_t req_reg;
  logic [3:0] port_reg;
  logic hit_reg;
  logic [15:0] sink_map_eff;
  logic [2:0] bat_count;
  logic [3:0] nth_port;
  logic nth_found;
  logic wr_en, rd_setup, addr_ok, bat_sel_ok;
  logic [31:0] rd_word;
  logic [31:0] desc_word;

  // byte lane of a word; lane 0 is the least significant byte
  function automatic logic [7:0] lane_of(input logic [31:0] w, input logic [1:0] l);
    lane_of = w[8*l +: 8];
  endfunction

  // number of consumer-capable ports
  function automatic logic [4:0] ones16(input logic [15:0] m);
    ones16 = 5'h00;
    for (int i = 0; i < 16; i++) begin
      ones16 = ones16 + {4'h0, m[i]};
    end
  endfunction

  // a peripheral can only sink on its upstream port
  assign sink_map_eff = cfg_hub_reg ? sink_map_reg : {15'h0000, sink_map_reg[0]};
  // battery count is void unless a battery is a declared source
  assign bat_count = attr_reg[ORIGIN_BAT_BIT] ? attr_reg[ORIGIN_NBAT_LO +: 3] : 3'h0;
  // select 7 names no record; its windows read zero instead of an unknown
  assign bat_sel_ok = (bat_sel_reg < 3'(NUM_BATS));

  pcd_nth_port u_pcd_nth_port (
    .port_map(sink_map_eff),
    .nth(req_reg.index),
    .port_num(nth_port),
    .found(nth_found)
  );

  // apb: zero wait states, read data latched during setup
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !addr_ok;

  // address decode and read view
  always_comb begin
    addr_ok = 1'b1;
    rd_word = 32'h00000000;
    unique case (paddr)
      ATTR_OFS: rd_word = {16'h0000, attr_reg};
      SINK_MAP_OFS: rd_word = {16'h0000, sink_map_eff};
      CFG_OFS: rd_word = {31'h00000000, cfg_hub_reg};
      REL_BC_OFS: rd_word = {16'h0000, rel_bc_reg};
      REL_PD_OFS: rd_word = {16'h0000, rel_pd_reg};
      REL_TC_OFS: rd_word = {16'h0000, rel_tc_reg};
      BAT_SEL_OFS: rd_word = {29'h00000000, bat_sel_reg};
      BAT_STR_OFS: rd_word = bat_sel_ok ? bat_str[bat_sel_reg] : 32'h00000000;
      BAT_FULL_OFS: rd_word = bat_sel_ok ? bat_full[bat_sel_reg] : 32'h00000000;
      BAT_BOOT_OFS: rd_word = bat_sel_ok ? bat_boot[bat_sel_reg] : 32'h00000000;
      BAT_DESIGN_OFS: rd_word = bat_sel_ok ? bat_design[bat_sel_reg] : 32'h00000000;
      BAT_RECENT_OFS: rd_word = bat_sel_ok ? bat_recent[bat_sel_reg] : 32'h00000000;
      PORT_SEL_OFS: rd_word = {28'h0000000, port_sel_reg};
      PORT_METHOD_OFS: rd_word = {29'h00000000, port_method[port_sel_reg]};
      PORT_VOLT_OFS: rd_word = port_volt[port_sel_reg];
      PORT_STEADY_OFS: rd_word = port_steady[port_sel_reg];
      PORT_BURST_OFS: rd_word = port_burst[port_sel_reg];
      PORT_DUR_OFS: rd_word = port_dur[port_sel_reg];
      STATUS_OFS: rd_word = {15'h0000, state_reg != ST_IDLE, 5'h00, bat_count, 3'h0, ones16(sink_map_eff)};
      default: addr_ok = 1'b0;
    endcase
  end

  // read data register; unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end

  // global configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attr_reg <= 16'h0000;
      sink_map_reg <= 16'h0000;
      cfg_hub_reg <= 1'b0;
      rel_bc_reg <= REL_BC_RESET;
      rel_pd_reg <= 16'h0000;
      rel_tc_reg <= 16'h0000;
      bat_sel_reg <= 3'h0;
      port_sel_reg <= 4'h0;
    end else if (wr_en) begin
      unique case (paddr)
        ATTR_OFS: attr_reg <= pwdata[15:0] & ATTR_WRITABLE; // reserved bits 7, 15 stay zero
        SINK_MAP_OFS: sink_map_reg <= pwdata[15:0];
        CFG_OFS: cfg_hub_reg <= pwdata[0];
        REL_BC_OFS: rel_bc_reg <= pwdata[15:0];
        REL_PD_OFS: rel_pd_reg <= pwdata[15:0];
        REL_TC_OFS: rel_tc_reg <= pwdata[15:0];
        BAT_SEL_OFS: bat_sel_reg <= pwdata[2:0];
        PORT_SEL_OFS: port_sel_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // battery records, reached through the battery select window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_BATS; i++) begin
        bat_str[i] <= '0;
        bat_full[i] <= 32'h00000000;
        bat_boot[i] <= 32'h00000000;
        bat_design[i] <= 32'h00000000;
        bat_recent[i] <= 32'h00000000;
      end
    end else if (wr_en && bat_sel_ok) begin
      unique case (paddr)
        BAT_STR_OFS: bat_str[bat_sel_reg] <= pwdata;
        BAT_FULL_OFS: bat_full[bat_sel_reg] <= pwdata;
        BAT_BOOT_OFS: bat_boot[bat_sel_reg] <= pwdata;
        BAT_DESIGN_OFS: bat_design[bat_sel_reg] <= pwdata;
        BAT_RECENT_OFS: bat_recent[bat_sel_reg] <= pwdata;
        default: ;
      endcase
    end
  end

  // per-port sink records; duration defaults to unknown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        port_method[i] <= 3'h0;
        port_volt[i] <= 32'h00000000;
        port_steady[i] <= 32'h00000000;
        port_burst[i] <= 32'h00000000;
        port_dur[i] <= DUR_UNKNOWN;
      end
    end else if (wr_en) begin
      unique case (paddr)
        PORT_METHOD_OFS: port_method[port_sel_reg] <= pwdata[2:0] & METHOD_MASK;
        PORT_VOLT_OFS: port_volt[port_sel_reg] <= pwdata;
        PORT_STEADY_OFS: port_steady[port_sel_reg] <= pwdata;
        PORT_BURST_OFS: port_burst[port_sel_reg] <= pwdata;
        PORT_DUR_OFS: port_dur[port_sel_reg] <= pwdata;
        default: ;
      endcase
    end
  end

  // fetch sequencer: take, resolve descriptor, reply
  assign fetch_ready = (state_reg == ST_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      req_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (fetch_valid) begin
            req_reg <= fetch_req;
            state_reg <= ST_LOOKUP;
          end
        end
        ST_LOOKUP: state_reg <= ST_REPLY;
        ST_REPLY: state_reg <= ST_IDLE;
      endcase
    end
  end

  // resolve which port or battery the request names
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_reg <= 4'h0;
      hit_reg <= 1'b0;
    end else if (state_reg == ST_LOOKUP) begin
      port_reg <= nth_port;
      unique case (req_reg.kind)
        KIND_BAT: hit_reg <= {1'b0, req_reg.index} < {1'b0, bat_count};
        KIND_SINK: hit_reg <= nth_found;
        KIND_TAIL: hit_reg <= 1'b1;
        default: hit_reg <= 1'b0;
      endcase
    end
  end

  // descriptor laid out as little-endian words; reserved slots are zero
  always_comb begin
    desc_word = 32'h00000000;
    if (hit_reg) begin
      unique case (req_reg.kind)
        KIND_TAIL: begin
          unique case (req_reg.offset[4:2])
            3'h2: desc_word = {sink_map_eff, 16'h0000};
            3'h3: desc_word = {attr_reg[ATTR_PD_BIT] ? rel_pd_reg : 16'h0000,
                               attr_reg[ATTR_BC_BIT] ? rel_bc_reg : 16'h0000};
            3'h4: desc_word = {16'h0000, attr_reg[ATTR_TC_BIT] ? rel_tc_reg : 16'h0000};
            default: desc_word = 32'h00000000;
          endcase
        end
        KIND_BAT: begin
          unique case (req_reg.offset[4:2])
            3'h0: desc_word = {bat_str[req_reg.index[2:0]].name_idx, BAT_CAP_CODE, DEVCAP_TYPE, DESC_LEN};
            3'h1: desc_word = {8'h00, bat_str[req_reg.index[2:0]].ident,
                               bat_str[req_reg.index[2:0]].maker_idx, bat_str[req_reg.index[2:0]].serial_idx};
            3'h2: desc_word = bat_full[req_reg.index[2:0]];
            3'h3: desc_word = bat_boot[req_reg.index[2:0]];
            3'h4: desc_word = bat_design[req_reg.index[2:0]];
            3'h5: desc_word = bat_recent[req_reg.index[2:0]];
            default: desc_word = 32'h00000000;
          endcase
        end
        KIND_SINK: begin
          unique case (req_reg.offset[4:2])
            3'h0: desc_word = {8'h00, SINK_CAP_CODE, DEVCAP_TYPE, DESC_LEN};
            3'h1: desc_word = {port_volt[port_reg][15:0], 13'h0000, port_method[port_reg]};
            3'h2: desc_word = {16'h0000, port_volt[port_reg][31:16]};
            3'h3: desc_word = port_steady[port_reg];
            3'h4: desc_word = port_burst[port_reg];
            3'h5: desc_word = port_dur[port_reg];
            default: desc_word = 32'h00000000;
          endcase
        end
        default: desc_word = 32'h00000000;
      endcase
    end
  end

  // reply register; a missing descriptor answers zero with the miss flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_done <= 1'b0;
      fetch_byte <= 8'h00;
      fetch_miss <= 1'b0;
    end else begin
      fetch_done <= (state_reg == ST_REPLY);
      if (state_reg == ST_REPLY) begin
        fetch_byte <= lane_of(desc_word, req_reg.offset[1:0]);
        fetch_miss <= !hit_reg;
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // fetch handshake: reply three edges after taking, busy in between
  chk_fetch_latency: assert property (fetch_valid && fetch_ready |-> ##3 fetch_done)
    else $error("fetch reply not after three cycles");
  chk_fetch_refused: assert property (fetch_valid && fetch_ready |=> !fetch_ready ##1 !fetch_ready ##1 fetch_ready)
    else $error("fetch port not busy while a reply is prepared");
  chk_peripheral_map: assert property (!cfg_hub_reg |-> sink_map_eff[15:1] == 15'h0000)
    else $error("peripheral reports more than one sink port");
  // descriptor content at the reply
  chk_map_lsb_first: assert property (fetch_done && req_reg.kind == KIND_TAIL && req_reg.offset == 5'h0A
      |-> fetch_byte == sink_map_eff[7:0])
    else $error("sink port map low byte misplaced");
  chk_bc_release: assert property (fetch_done && req_reg.kind == KIND_TAIL && req_reg.offset == 5'h0D
      |-> fetch_byte == (attr_reg[ATTR_BC_BIT] ? rel_bc_reg[15:8] : 8'h00))
    else $error("charging release high byte wrong");
  chk_pd_hidden: assert property (fetch_done && req_reg.kind == KIND_TAIL && req_reg.offset == 5'h0E
      && !attr_reg[ATTR_PD_BIT] |-> fetch_byte == 8'h00)
    else $error("power delivery release shown while unsupported");
  chk_tc_hidden: assert property (fetch_done && req_reg.kind == KIND_TAIL && req_reg.offset == 5'h10
      && !attr_reg[ATTR_TC_BIT] |-> fetch_byte == 8'h00)
    else $error("type-c release shown while unsupported");
  chk_sink_reserved: assert property (fetch_done && req_reg.kind == KIND_SINK
      && (req_reg.offset == 5'h03 || req_reg.offset == 5'h0A || req_reg.offset == 5'h0B) |-> fetch_byte == 8'h00)
    else $error("reserved sink byte not zero");
  chk_bat_reserved: assert property (fetch_done && req_reg.kind == KIND_BAT && req_reg.offset == 5'h07
      |-> fetch_byte == 8'h00)
    else $error("reserved battery byte not zero");
  chk_method_upper: assert property (fetch_done && req_reg.kind == KIND_SINK && req_reg.offset == 5'h04
      |-> fetch_byte[7:3] == 5'h00)
    else $error("sink method reserved bits set");
  chk_length_byte: assert property (fetch_done && !fetch_miss && req_reg.kind != KIND_TAIL
      && req_reg.offset == 5'h00 |-> fetch_byte == DESC_LEN)
    else $error("descriptor length byte wrong");
  chk_port_order: assert property (fetch_done && !fetch_miss && req_reg.kind == KIND_SINK
      |-> sink_map_eff[port_reg] && ones16(sink_map_eff & ((16'h0001 << port_reg) - 16'h0001)) == {1'b0, req_reg.index})
    else $error("sink descriptor not in port order");
  chk_battery_count: assert property (fetch_done && !fetch_miss && req_reg.kind == KIND_BAT
      |-> attr_reg[ORIGIN_BAT_BIT] && req_reg.index < {1'b0, bat_count})
    else $error("battery descriptor beyond declared count");
  chk_miss_zero: assert property (fetch_done && fetch_miss |-> fetch_byte == 8'h00)
    else $error("missing descriptor answered with data");
  // register bus: unmapped reads flag an error and return zero
  chk_apb_unmapped: assert property (psel && penable && !addr_ok |-> pslverr && pready && (pwrite || prdata == 32'h00000000))
    else $error("unmapped access not flagged");

  // main scenarios
  cov_tail_fetch: cover property (fetch_done && !fetch_miss && req_reg.kind == KIND_TAIL);
  cov_sink_fetch: cover property (fetch_done && !fetch_miss && req_reg.kind == KIND_SINK);
  cov_bat_fetch: cover property (fetch_done && !fetch_miss && req_reg.kind == KIND_BAT);
  cov_miss: cover property (fetch_done && fetch_miss);
  cov_back_to_back: cover property (fetch_done && fetch_valid && fetch_ready);
endmodule

// ===== pcd_host_model.sv
`timescale 1ns/1ps
// host side of the fetch port: asks for one descriptor byte and waits for it
module pcd_host_model
  import pcd_pkg::*;
(
  input wire logic pclk,
  output logic fetch_valid,
  output pcd_fetch_req_t fetch_req,
  input wire logic fetch_ready,
  input wire logic fetch_done,
  input wire logic [7:0] fetch_byte,
  input wire logic fetch_miss
);
  // idle at time zero; request lines carry a pattern, never a stale value
  initial begin
    fetch_valid = 1'b0;
    fetch_req = 11'h555;
  end

  // gap idle cycles first, so the host can be slow or back to back
  task automatic fetch(input logic [1:0] kind, input logic [3:0] idx, input logic [4:0] ofs,
                       input int gap, output logic [7:0] data, output logic miss, output bit ok);
    int n;
    int w;
    repeat (gap) @(posedge pclk);
    fetch_valid <= 1'b1;
    fetch_req <= {kind, idx, ofs};
    n = 0;
    // request held until ready is seen at an edge
    do begin
      @(posedge pclk);
      n++;
    end while (fetch_ready !== 1'b1 && n < 20);
    fetch_valid <= 1'b0;
    fetch_req <= ~fetch_req; // released lines keep moving
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (fetch_done !== 1'b1 && w < 20);
    data = fetch_byte;
    miss = fetch_miss;
    ok = (n < 20) && (w < 20);
  endtask
endmodule

// ===== test_power_capability_descriptors.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("FAIL %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module test_power_capability_descriptors;
  import pcd_pkg::*;
  localparam logic [7:0] BAT_CODE = 8'h01;
  localparam logic [7:0] SINK_CODE = 8'h02;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fm;
  logic [7:0] paddr, fb;
  logic [31:0] pwdata, prdata, rd;
  logic fetch_valid, fetch_ready, fetch_done, fetch_miss;
  pcd_fetch_req_t fetch_req;
  logic [7:0] fetch_byte;
  logic [7:0] exp_d [24];
  int error_cnt, num_checks;

  pcd_desc_gen #(.BAT_CAP_CODE(BAT_CODE), .SINK_CAP_CODE(SINK_CODE)) u_pcd_desc_gen (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fetch_valid(fetch_valid),
    .fetch_req(fetch_req), .fetch_ready(fetch_ready), .fetch_done(fetch_done), .fetch_byte(fetch_byte),
    .fetch_miss(fetch_miss));
  pcd_host_model u_pcd_host_model (
    .pclk(pclk), .fetch_valid(fetch_valid), .fetch_req(fetch_req), .fetch_ready(fetch_ready),
    .fetch_done(fetch_done), .fetch_byte(fetch_byte), .fetch_miss(fetch_miss));

  // 50 MHz clock
  always #10 pclk = ~pclk;

  // one apb transfer; an idle cycle after it so psel is never set twice in one step
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    `CHK("apb answer", 1'b1, pready)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic get(input logic [1:0] kind, input logic [3:0] idx, input int ofs);
    bit ok;
    u_pcd_host_model.fetch(kind, idx, ofs[4:0], ofs % 3, fb, fm, ok);
    `CHK("fetch handshake", 1'b1, ok)
  endtask

  // expected descriptor: header bytes, everything else zero until put
  task automatic hdr(input logic [7:0] code);
    foreach (exp_d[i]) exp_d[i] = 8'h00;
    exp_d[0] = DESC_LEN;
    exp_d[1] = DEVCAP_TYPE;
    exp_d[2] = code;
  endtask

  task automatic put(input int ofs, input logic [31:0] v, input int nb);
    for (int i = 0; i < nb; i++) exp_d[ofs + i] = v[8*i +: 8];
  endtask

  task automatic cmp_desc(input logic [1:0] kind, input logic [3:0] idx);
    for (int o = 0; o < 24; o++) begin
      get(kind, idx, o);
      `CHK("descriptor byte", exp_d[o], fb)
      `CHK("descriptor miss", 1'b0, fm)
    end
  endtask

  task automatic t_reset;
    apb(REL_BC_OFS, 1'b0, 32'h0);
    `CHK("charging release reset", 32'h0000_0120, rd)
    apb(PORT_DUR_OFS, 1'b0, 32'h0);
    `CHK("duration reset", DUR_UNKNOWN, rd)
    apb(8'h4C, 1'b0, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    get(KIND_TAIL, 4'h0, 12);
    `CHK("charging release hidden", 8'h00, fb)
    get(KIND_BAT, 4'h0, 0);
    `CHK("battery without source", 1'b1, fm)
  endtask

  task automatic t_tail;
    apb(ATTR_OFS, 1'b1, 32'h0000_0046);
    apb(CFG_OFS, 1'b1, 32'h1);
    apb(SINK_MAP_OFS, 1'b1, 32'h0000_8201);
    apb(REL_PD_OFS, 1'b1, 32'h0000_0300);
    apb(REL_TC_OFS, 1'b1, 32'h0000_0210);
    hdr(8'h00);
    put(10, 32'h8201, 2);
    put(12, 32'h0120, 2);
    put(14, 32'h0300, 2);
    put(16, 32'h0210, 2);
    for (int o = 10; o < 18; o++) begin
      get(KIND_TAIL, 4'h0, o);
      `CHK("tail byte", exp_d[o], fb)
    end
    // only charging advertised: the other two releases must vanish
    apb(ATTR_OFS, 1'b1, 32'h0000_0002);
    get(KIND_TAIL, 4'h0, 12);
    `CHK("charging release low", 8'h20, fb)
    get(KIND_TAIL, 4'h0, 14);
    `CHK("pd release hidden", 8'h00, fb)
    get(KIND_TAIL, 4'h0, 17);
    `CHK("typec release hidden", 8'h00, fb)
  endtask

  task automatic t_battery;
    apb(ATTR_OFS, 1'b1, 32'h0000_1200); // battery source, two batteries
    for (int i = 0; i < 2; i++) begin
      apb(BAT_SEL_OFS, 1'b1, i);
      apb(BAT_STR_OFS, 1'b1, {8'h11 + 8'(i), 8'h22, 8'h33, 8'h40 + 8'(i)});
      apb(BAT_FULL_OFS, 1'b1, 32'h1234_5678 + i);
      apb(BAT_BOOT_OFS, 1'b1, 32'h0A0B_0C0D);
      apb(BAT_DESIGN_OFS, 1'b1, 32'hFEDC_BA98);
      apb(BAT_RECENT_OFS, 1'b1, 32'h8000_0001);
    end
    hdr(BAT_CODE);
    put(3, 32'h4133_2212, 4);
    put(8, 32'h1234_5679, 4);
    put(12, 32'h0A0B_0C0D, 4);
    put(16, 32'hFEDC_BA98, 4);
    put(20, 32'h8000_0001, 4);
    cmp_desc(KIND_BAT, 4'h1);
    get(KIND_BAT, 4'h0, 6);
    `CHK("first battery id", 8'h40, fb)
    get(KIND_BAT, 4'h2, 0);
    `CHK("third battery absent", 1'b1, fm)
  endtask

  // hub with sink ports 3 and 9; port 9 keeps the unknown duration
  task automatic t_sink;
    apb(CFG_OFS, 1'b1, 32'h1);
    apb(SINK_MAP_OFS, 1'b1, 32'h0000_0208);
    apb(PORT_SEL_OFS, 1'b1, 32'h3);
    apb(PORT_METHOD_OFS, 1'b1, 32'h0000_FFFF);
    apb(PORT_VOLT_OFS, 1'b1, 32'h0190_0064);
    apb(PORT_STEADY_OFS, 1'b1, 32'h0000_1388);
    apb(PORT_BURST_OFS, 1'b1, 32'h0001_2345);
    apb(PORT_DUR_OFS, 1'b1, 32'h0000_0032);
    apb(PORT_SEL_OFS, 1'b1, 32'h9);
    apb(PORT_METHOD_OFS, 1'b1, 32'h2);
    apb(PORT_VOLT_OFS, 1'b1, 32'h0154_00F0);
    apb(PORT_STEADY_OFS, 1'b1, 32'h0000_2710);
    apb(PORT_BURST_OFS, 1'b1, 32'h0000_4E20);
    hdr(SINK_CODE);
    put(4, 32'h7, 2);
    put(6, 32'h0064, 2);
    put(8, 32'h0190, 2);
    put(12, 32'h1388, 4);
    put(16, 32'h0001_2345, 4);
    put(20, 32'h32, 4);
    cmp_desc(KIND_SINK, 4'h0);
    hdr(SINK_CODE);
    put(4, 32'h2, 2);
    put(6, 32'h00F0, 2);
    put(8, 32'h0154, 2);
    put(12, 32'h2710, 4);
    put(16, 32'h4E20, 4);
    put(20, DUR_UNKNOWN, 4);
    cmp_desc(KIND_SINK, 4'h1);
    get(KIND_SINK, 4'h2, 0);
    `CHK("third sink absent", 1'b1, fm)
    apb(STATUS_OFS, 1'b0, 32'h0);
    `CHK("status counts", 32'h0000_0202, rd)
  endtask

  // peripheral: only the upstream port may be a sink
  task automatic t_periph;
    apb(CFG_OFS, 1'b1, 32'h0);
    apb(SINK_MAP_OFS, 1'b1, 32'h0000_0209);
    get(KIND_TAIL, 4'h0, 10);
    `CHK("peripheral map low", 8'h01, fb)
    get(KIND_TAIL, 4'h0, 11);
    `CHK("peripheral map high", 8'h00, fb)
    hdr(SINK_CODE);
    put(20, DUR_UNKNOWN, 4);
    cmp_desc(KIND_SINK, 4'h0);
    get(KIND_SINK, 4'h1, 0);
    `CHK("second peripheral sink", 1'b1, fm)
    apb(SINK_MAP_OFS, 1'b0, 32'h0);
    `CHK("peripheral map read", 32'h0000_0001, rd)
    apb(ATTR_OFS, 1'b1, 32'h0000_FFFF);
    apb(ATTR_OFS, 1'b0, 32'h0);
    `CHK("attribute reserved bits", 32'h0000_7F7F, rd)
  endtask

  task results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("FAIL watchdog expected finish seen timeout");
    results();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_tail();
    t_battery();
    t_sink();
    t_periph();
    results();
  end
endmodule
